// ==== hw/rbw_top.sv ====
/*
 * rbw_top: boot rom width control, instruction fetch sequencer and clock
 * prescaler control, with an APB register slave.
 * assumes: the core and the rom port run on pclk; rom_ack answers rom_rd
 * with rom_rdata in the same cycle; paddr carries the page offset only.
 */
`timescale 1ns/1ps

module rbw_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fetch_en,
   input wire logic jump_valid,
   input wire logic [31:0] jump_addr,
   output logic instr_valid,
   output rbw_pkg::rbw_instr_t instr,
   output logic rom_rd,
   output logic [31:0] rom_addr,
   input wire logic [31:0] rom_rdata,
   input wire logic rom_ack,
   output logic [7:0] rom_ctrl,
   output logic [2:0] clk_div2,
   output logic [2:0] clk_tick
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   rbw_pkg::rbw_fetch_t state;
   logic [31:0] fetch_pc;
   logic mode16;
   logic [15:0] low_half;
   logic setup;
   logic access;
   logic mapped;
   logic [31:0] read_mux;

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign setup = psel && !penable;
   assign access = psel && penable && pready;

   // address decode and read data selection
   always_comb begin
      mapped = 1'b1;
      read_mux = 32'h0000_0000;
      unique case (paddr)
         rbw_pkg::ADDR_ROM_CTRL: read_mux = {24'h00_0000, rom_ctrl};
         rbw_pkg::ADDR_CLK_DIV: read_mux = {29'h0000_0000, clk_div2};
         rbw_pkg::ADDR_STATUS: begin
            read_mux[rbw_pkg::STAT_BUSY_BIT] = (state != rbw_pkg::st_idle);
            read_mux[rbw_pkg::STAT_WIDTH16_BIT] = mode16;
         end
         rbw_pkg::ADDR_FETCH_PC: read_mux = fetch_pc;
         default: mapped = 1'b0;
      endcase
   end

   // answer in the access phase that follows the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : read_mux;
         pslverr <= !mapped;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   // rom control: byte lane 0 write switches width, timing and burst
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rom_ctrl <= rbw_pkg::ROM_CTRL_RESET;
      end else if (access && pwrite && pstrb[0] && paddr == rbw_pkg::ADDR_ROM_CTRL) begin
         rom_ctrl <= pwdata[7:0];
      end
   end

   // clock divider control: one bit per clock, set means divide by 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_div2 <= rbw_pkg::CLK_DIV_RESET;
      end else if (access && pwrite && pstrb[0] && paddr == rbw_pkg::ADDR_CLK_DIV) begin
         clk_div2 <= pwdata[2:0];
      end
   end

   // ----------------------------------------------------------------
   // prescalers
   // ----------------------------------------------------------------
   // tick marks each internal clock edge: every pclk or every other
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_tick <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            clk_tick[i] <= clk_div2[i] ? !clk_tick[i] : 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // fetch sequencer
   // ----------------------------------------------------------------
   // width is caught when a fetch begins and held until it ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode16 <= rbw_pkg::ROM_CTRL_RESET[rbw_pkg::ROM_WIDTH16_BIT];
      end else if (state == rbw_pkg::st_idle && fetch_en && !jump_valid) begin
         mode16 <= rom_ctrl[rbw_pkg::ROM_WIDTH16_BIT];
      end
   end

   // state, program counter and rom requests
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= rbw_pkg::st_idle;
         fetch_pc <= rbw_pkg::RESET_VECTOR;
         rom_rd <= 1'b0;
         rom_addr <= rbw_pkg::RESET_VECTOR;
         low_half <= 16'h0000;
         instr_valid <= 1'b0;
         instr <= '0;
      end else begin
         instr_valid <= 1'b0;
         unique case (state)
            rbw_pkg::st_idle: begin
               if (jump_valid) begin
                  fetch_pc <= jump_addr;
               end else if (fetch_en) begin
                  rom_rd <= 1'b1;
                  rom_addr <= fetch_pc;
                  state <= rbw_pkg::st_lo;
               end
            end
            rbw_pkg::st_lo: begin
               if (rom_ack) begin
                  if (mode16) begin
                     low_half <= rom_rdata[15:0];
                     rom_addr <= 32'(fetch_pc + rbw_pkg::HALF_OFFSET);
                     state <= rbw_pkg::st_hi;
                  end else begin
                     rom_rd <= 1'b0;
                     instr_valid <= 1'b1;
                     instr <= '{addr: fetch_pc, data: rom_rdata};
                     fetch_pc <= 32'(fetch_pc + rbw_pkg::STEP_32);
                     state <= rbw_pkg::st_idle;
                  end
               end
            end
            rbw_pkg::st_hi: begin
               if (rom_ack) begin
                  rom_rd <= 1'b0;
                  instr_valid <= 1'b1;
                  instr <= '{addr: fetch_pc, data: {rom_rdata[15:0], low_half}};
                  fetch_pc <= 32'(fetch_pc + rbw_pkg::STEP_16);
                  state <= rbw_pkg::st_idle;
               end
            end
            default: state <= rbw_pkg::st_idle;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic [1:0] since_reset;

   // counts the first cycles after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         since_reset <= 2'h0;
      end else if (since_reset != 2'h3) begin
         since_reset <= 2'(since_reset + 2'h1);
      end
   end

   boot_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      since_reset == 2'h0 |-> rom_ctrl == rbw_pkg::ROM_CTRL_RESET && mode16)
      else $error("rom width not 16-bit after reset");

   first_fetch_a: assert property (@(posedge pclk) disable iff (!presetn)
      since_reset == 2'h0 |-> fetch_pc == rbw_pkg::RESET_VECTOR && rom_addr == 32'h0)
      else $error("first fetch not at address zero");

   high_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_lo && rom_ack && mode16
      |=> rom_rd && rom_addr == $past(rom_addr) + rbw_pkg::HALF_OFFSET)
      else $error("upper half not read four bytes higher");

   half_join_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_hi && rom_ack
      |=> instr_valid && instr.data == {$past(rom_rdata[15:0]), $past(low_half)})
      else $error("16-bit word not built from low halves");

   byte_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && pstrb[0] && paddr == rbw_pkg::ADDR_ROM_CTRL
      |=> rom_ctrl == $past(pwdata[7:0]))
      else $error("rom control byte write lost");

   zero_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_idle && fetch_en && !jump_valid && rom_ctrl == 8'h00
      |=> !mode16)
      else $error("zero write did not select 32-bit width");

   width_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      state != rbw_pkg::st_idle |=> $stable(mode16))
      else $error("width changed during a fetch");

   div_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
      since_reset == 2'h0 |-> clk_div2 == rbw_pkg::CLK_DIV_RESET)
      else $error("prescalers not divide-by-2 after reset");

   tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_div2[2] && $past(clk_div2[2]) && clk_tick[2] |=> !clk_tick[2] || !clk_div2[2])
      else $error("divide-by-2 tick ran at full rate");

   reset_order_a: assert property (@(posedge pclk) disable iff (!presetn)
      since_reset == 2'h0
      |-> state == rbw_pkg::st_idle && mode16 && clk_div2 == rbw_pkg::CLK_DIV_RESET)
      else $error("fetch began before defaults restored");

   // ----------------------------------------------------------------
   // register bus and fetch start checks
   // ----------------------------------------------------------------
   // the slave answers once per setup and flags offsets it does not map
   ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready stood for more than one cycle");

   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !mapped |=> pready && pslverr)
      else $error("unmapped offset not flagged");

   div_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      access && pwrite && pstrb[0] && paddr == rbw_pkg::ADDR_CLK_DIV
      |=> clk_div2 == $past(pwdata[2:0]))
      else $error("clock divider write lost");

   // a fetch starts at the program counter with the width then in force
   fetch_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_idle && fetch_en && !jump_valid
      |=> rom_rd && rom_addr == $past(fetch_pc))
      else $error("fetch did not start at the program counter");

   width_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_idle && fetch_en && !jump_valid
      |=> mode16 == $past(rom_ctrl[rbw_pkg::ROM_WIDTH16_BIT]))
      else $error("fetch width not taken from rom control");

   jump_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_idle && jump_valid |=> fetch_pc == $past(jump_addr))
      else $error("jump address not loaded");

   // ----------------------------------------------------------------
   // program counter steps and prescaler checks
   // ----------------------------------------------------------------
   // two rom words per instruction in 16-bit mode, one in 32-bit mode
   step16_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_hi && rom_ack |=> fetch_pc == $past(fetch_pc) + rbw_pkg::STEP_16)
      else $error("16-bit fetch did not step by two words");

   step32_a: assert property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_lo && rom_ack && !mode16
      |=> fetch_pc == $past(fetch_pc) + rbw_pkg::STEP_32)
      else $error("32-bit fetch did not step by one word");

   // an undivided clock ticks on every pclk edge
   tick_div1_a: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_tick | $past(clk_div2)) == 3'h7)
      else $error("undivided clock missed a tick");

   fetch16_c: cover property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_hi && rom_ack);
   fetch32_c: cover property (@(posedge pclk) disable iff (!presetn)
      state == rbw_pkg::st_lo && rom_ack && !mode16);
   switch_c: cover property (@(posedge pclk) disable iff (!presetn)
      state != rbw_pkg::st_idle && rom_ctrl[rbw_pkg::ROM_WIDTH16_BIT] != mode16);
   div1_c: cover property (@(posedge pclk) disable iff (!presetn) clk_div2 == 3'h0);

endmodule

// ==== hw/rbw_pkg.sv ====
/*
 * rbw_pkg: constants and types for the boot-width and clock-prescaler block.
 * assumes: APB offsets are byte addresses within the control register page.
 */
package rbw_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [31:0] CTRL_BASE = 32'h0320_0000; // control register base
   localparam logic [7:0] ADDR_ROM_CTRL = 8'h80;
   localparam logic [7:0] ADDR_CLK_DIV = 8'h84;
   localparam logic [7:0] ADDR_STATUS = 8'h88;
   localparam logic [7:0] ADDR_FETCH_PC = 8'h8c;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int ROM_WIDTH16_BIT = 6;
   localparam logic [7:0] ROM_CTRL_RESET = 8'h40;
   localparam logic [2:0] CLK_DIV_RESET = 3'h7; // cpu, mem, io all divide by 2
   localparam int CLK_DIV_CPU_BIT = 0;
   localparam int CLK_DIV_MEM_BIT = 1;
   localparam int CLK_DIV_IO_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_WIDTH16_BIT = 1;

   // ----------------------------------------------------------------
   // fetch addressing
   // ----------------------------------------------------------------
   localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
   localparam logic [31:0] HALF_OFFSET = 32'h0000_0004;
   localparam logic [31:0] STEP_16 = 32'h0000_0008;
   localparam logic [31:0] STEP_32 = 32'h0000_0004;

   typedef enum logic [1:0] {st_idle, st_lo, st_hi} rbw_fetch_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
   } rbw_instr_t;

endpackage

// ==== bench/rbw_rom_model.sv ====
/*
 * rbw_rom_model: behavioural boot rom bank behind the fetch port.
 * assumes: runs on pclk; answers rom_rd after wait_cycles with a one-cycle rom_ack.
 */
`timescale 1ns/1ps
module rbw_rom_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rom_rd,
   input wire logic [31:0] rom_addr,
   input wire logic [7:0] wait_cycles,
   output logic [31:0] rom_rdata,
   output logic rom_ack
);
   // ----------------------------------------------------------------
   // word answer
   // ----------------------------------------------------------------
   logic [7:0] cnt;

   // ack with the addressed word, walking pattern on the bus otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         rom_ack <= 1'b0;
         rom_rdata <= 32'h0000_0001;
      end else begin
         rom_ack <= 1'b0;
         rom_rdata <= {rom_rdata[30:0], ~rom_rdata[31]}; // never the last word
         cnt <= 8'h00;
         if (rom_rd && !rom_ack) begin
            if (cnt >= wait_cycles) begin
               rom_ack <= 1'b1;
               rom_rdata <= {rom_addr[15:0] ^ 16'hbeef, rom_addr[15:0] + 16'h1000};
            end else begin
               cnt <= cnt + 8'h01;
            end
         end
      end
   end
endmodule

// ==== bench/rbw_top_tb.sv ====
/*
 * rbw_top_tb: apb and fetch sequences against the boot width block.
 * assumes: rbw_rom_model on the rom port; 40 mhz pclk.
 */
`timescale 1ns/1ps
module rbw_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic fetch_en = 1'b0;
   logic jump_valid = 1'b0;
   logic [31:0] jump_addr = 32'h0;
   logic [7:0] rom_wait = 8'h00;
   logic [31:0] prdata, rom_addr, rom_rdata, rd;
   logic pready, pslverr, instr_valid, rom_rd, rom_ack, err;
   rbw_pkg::rbw_instr_t instr;
   logic [7:0] rom_ctrl;
   logic [2:0] clk_div2, clk_tick, t0;
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;

   rbw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fetch_en(fetch_en), .jump_valid(jump_valid),
      .jump_addr(jump_addr), .instr_valid(instr_valid), .instr(instr), .rom_rd(rom_rd),
      .rom_addr(rom_addr), .rom_rdata(rom_rdata), .rom_ack(rom_ack), .rom_ctrl(rom_ctrl),
      .clk_div2(clk_div2), .clk_tick(clk_tick));
   rbw_rom_model rom (.pclk(pclk), .presetn(presetn), .rom_rd(rom_rd), .rom_addr(rom_addr),
      .wait_cycles(rom_wait), .rom_rdata(rom_rdata), .rom_ack(rom_ack));

   // ----------------------------------------------------------------
   // clock, timeout and helpers
   // ----------------------------------------------------------------
   always #12.5 pclk = ~pclk;

   // cut a hang short
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares = miscompares + 1;
         stop_test();
      end
   end

   function automatic logic [15:0] lo(input logic [31:0] a);
      return a[15:0] + 16'h1000;
   endfunction

   task automatic stop_test();
      if (miscompares == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
      n_compared = n_compared + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // one instruction fetch, compared as {addr, data}
   task automatic fetch(input logic [31:0] ea, input logic [31:0] ed);
      @(posedge pclk);
      fetch_en <= 1'b1;
      @(posedge pclk);
      fetch_en <= 1'b0;
      while (instr_valid !== 1'b1) @(posedge pclk);
      chk("instr", {ea, ed}, instr);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h80, 32'h0, 4'h0);
      chk("rom_ctrl reg", 64'h40, rd);
      apb(1'b0, 8'h84, 32'h0, 4'h0);
      chk("clk_div reg", 64'h7, rd);
      apb(1'b0, 8'h90, 32'h0, 4'h0);
      chk("unmapped err", 64'h1, err);
      apb(1'b0, 8'h88, 32'h0, 4'h0);
      chk("status reset", 64'h2, rd);
      t0 = clk_tick;
      @(posedge pclk);
      chk("tick toggle", 64'h7, t0 ^ clk_tick);
      fetch(32'h0, {lo(32'h4), lo(32'h0)});
      apb(1'b0, 8'h8c, 32'h0, 4'h0);
      chk("fetch pc 16", 64'h8, rd);
      rom_wait <= 8'h05;
      fork
         fetch(32'h8, {lo(32'hc), lo(32'h8)});
         begin
            repeat (3) @(posedge pclk);
            apb(1'b1, 8'h80, 32'hffff_ff00, 4'h1);
         end
      join
      apb(1'b0, 8'h80, 32'h0, 4'h0);
      chk("rom_ctrl zero", 64'h0, rd);
      fetch(32'h10, {16'h0010 ^ 16'hbeef, lo(32'h10)});
      apb(1'b0, 8'h88, 32'h0, 4'h0);
      chk("status 32", 64'h0, rd);
      apb(1'b0, 8'h8c, 32'h0, 4'h0);
      chk("fetch pc 32", 64'h14, rd);
      @(posedge pclk);
      jump_valid <= 1'b1;
      jump_addr <= 32'h20;
      @(posedge pclk);
      jump_valid <= 1'b0;
      fetch(32'h20, {16'h0020 ^ 16'hbeef, lo(32'h20)});
      apb(1'b1, 8'h80, 32'h40, 4'h0);
      apb(1'b0, 8'h80, 32'h0, 4'h0);
      chk("strobe off", 64'h0, rd);
      apb(1'b1, 8'h84, 32'h0, 4'h1);
      repeat (2) @(posedge pclk);
      chk("div1 tick", 64'h7, {clk_div2, clk_tick});
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("reset ports", {8'h40, 3'h7}, {rom_ctrl, clk_div2});
      presetn <= 1'b1;
      fetch(32'h0, {lo(32'h4), lo(32'h0)});
      stop_test();
   end
endmodule
